// File: logic/hcr_register_set.sv
// Byte-wide configuration register set of the hub, loaded by EEPROM or SMBus
//
// Function
// - Every register readable; writable only under SMBus or EEPROM source, the command register under SMBus only
// - EEPROM source: all registers reset to zero
// - Command register only present in SMBus mode
// - Vendor id low at 00, high at 01
// - Product id low at 02, high at 03
// - Internal defaults: 9b, 20, 02 config bytes
// - Internal defaults: controller current 01 and 32
// - Three string lengths, three zeroed string ranges
// - Charging enable register defaults to zero
// - Fixed-port flags default to zero
`timescale 1ns/100ps
`include "hcr_cfg.svh"

module hcr_register_set (
    // Clock, reset and enable
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Configuration select pins
    input wire logic [1:0] cfg_select_in,
    // Byte access from the SMBus slave or EEPROM loader
    input wire hcr_pkg::hcr_access_t access_in,
    input wire logic load_done_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // Configuration status and contents
    output hcr_pkg::hcr_source_t source_out,
    output logic smbus_mode_out,
    output logic eeprom_mode_out,
    output logic config_ready_out,
    output hcr_pkg::hcr_settings_t settings_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Select pin synchroniser and source capture

    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    hcr_pkg::hcr_state_t state;
    hcr_pkg::hcr_source_t source;
    logic [7:0] mem [0:`HCR_SPACE-1];
    logic [7:0] command;
    logic is_smbus;
    logic load_defaults;
    logic write_hit;

    // Two-stage synchroniser on the select pins
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sel_meta <= 2'h0;
            sel_sync <= 2'h0;
        end else if (clk_en_in) begin
            sel_meta <= cfg_select_in;
            sel_sync <= sel_meta;
        end
    end

    // Strap wait for three cycles, then latch the source once
    logic [1:0] strap_wait;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_wait <= 2'h0;
        end else if (clk_en_in && strap_wait != 2'h3) begin
            strap_wait <= strap_wait + 2'h1;
        end
    end

    // Configuration sequencing
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= hcr_pkg::HCR_ST_WAIT_STRAP;
            source <= hcr_pkg::HCR_SRC_DEFAULT;
        end else if (clk_en_in) begin
            unique case (state)
                hcr_pkg::HCR_ST_WAIT_STRAP: begin
                    if (strap_wait == 2'h3) begin
                        source <= hcr_pkg::hcr_source_t'(sel_sync);
                        if (sel_sync == `HCR_SEL_SMBUS || sel_sync == `HCR_SEL_EEPROM) begin
                            state <= hcr_pkg::HCR_ST_LOAD;
                        end else begin
                            state <= hcr_pkg::HCR_ST_READY;
                        end
                    end
                end
                hcr_pkg::HCR_ST_LOAD: begin
                    if (load_done_in) begin
                        state <= hcr_pkg::HCR_ST_READY;
                    end
                end
                hcr_pkg::HCR_ST_READY: begin
                    state <= hcr_pkg::HCR_ST_READY;
                end
            endcase
        end
    end

    assign is_smbus = (source == hcr_pkg::HCR_SRC_SMBUS);
    assign load_defaults = clk_en_in && state == hcr_pkg::HCR_ST_WAIT_STRAP
        && strap_wait == 2'h3
        && !(sel_sync == `HCR_SEL_SMBUS || sel_sync == `HCR_SEL_EEPROM);
    // External writes only while an external source owns the set
    assign write_hit = clk_en_in && access_in.wr && state != hcr_pkg::HCR_ST_WAIT_STRAP
        && (source == hcr_pkg::HCR_SRC_SMBUS || source == hcr_pkg::HCR_SRC_EEPROM);

    ////////////////////////////////////////////////////////////////////////////
    // Byte register storage

    // Default image for internal configuration
    function automatic logic [7:0] hcr_default(input logic [7:0] ofs);
        logic [7:0] val;
        val = `HCR_RST_ZERO;
        unique case (ofs)
            `HCR_OFS_CFG_ONE: val = `HCR_RST_CFG_ONE;
            `HCR_OFS_CFG_TWO: val = `HCR_RST_CFG_TWO;
            `HCR_OFS_CFG_THREE: val = `HCR_RST_CFG_THREE;
            `HCR_OFS_BUDGET_SELF: val = `HCR_RST_BUDGET_SELF;
            `HCR_OFS_BUDGET_BUS: val = `HCR_RST_BUDGET_BUS;
            `HCR_OFS_CURR_SELF: val = `HCR_RST_CURR_SELF;
            `HCR_OFS_CURR_BUS: val = `HCR_RST_CURR_BUS;
            `HCR_OFS_POWER_DELAY: val = `HCR_RST_POWER_DELAY;
            default: val = `HCR_RST_ZERO;
        endcase
        return val;
    endfunction

    // Zero at reset, defaults when internal, external bytes otherwise
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < `HCR_SPACE; i++) begin
                mem[i] <= `HCR_RST_ZERO;
            end
        end else if (load_defaults) begin
            for (int i = 0; i < `HCR_SPACE; i++) begin
                mem[i] <= hcr_default(i[7:0]);
            end
        end else if (write_hit && access_in.addr != `HCR_OFS_COMMAND) begin
            mem[access_in.addr] <= access_in.wdata;
        end
    end

    // Command register exists only under SMBus configuration
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            command <= `HCR_RST_ZERO;
        end else if (write_hit && is_smbus && access_in.addr == `HCR_OFS_COMMAND) begin
            command <= access_in.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
            rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            rvalid_out <= access_in.rd;
            if (access_in.rd) begin
                if (access_in.addr == `HCR_OFS_COMMAND) begin
                    rdata_out <= is_smbus ? command : 8'h00;
                end else begin
                    rdata_out <= mem[access_in.addr];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings seen by the hub core

    assign source_out = source;
    assign smbus_mode_out = is_smbus;
    assign eeprom_mode_out = (source == hcr_pkg::HCR_SRC_EEPROM);
    assign config_ready_out = (state == hcr_pkg::HCR_ST_READY);

    always_comb begin
        settings_out.vendor_id = {mem[`HCR_OFS_VENDOR_HIGH], mem[`HCR_OFS_VENDOR_LOW]};
        settings_out.product_id = {mem[`HCR_OFS_PRODUCT_HIGH],
            mem[`HCR_OFS_PRODUCT_LOW]};
        settings_out.release_number = {mem[`HCR_OFS_RELEASE_HIGH], mem[`HCR_OFS_RELEASE_LOW]};
        settings_out.config_one = mem[`HCR_OFS_CFG_ONE];
        settings_out.config_two = mem[`HCR_OFS_CFG_TWO];
        settings_out.config_three = mem[`HCR_OFS_CFG_THREE];
        settings_out.fixed_ports = mem[`HCR_OFS_FIXED_PORTS];
        settings_out.off_self = mem[`HCR_OFS_OFF_SELF];
        settings_out.off_bus = mem[`HCR_OFS_OFF_BUS];
        settings_out.budget_self = mem[`HCR_OFS_BUDGET_SELF];
        settings_out.budget_bus = mem[`HCR_OFS_BUDGET_BUS];
        settings_out.current_self = mem[`HCR_OFS_CURR_SELF];
        settings_out.current_bus = mem[`HCR_OFS_CURR_BUS];
        settings_out.power_delay = mem[`HCR_OFS_POWER_DELAY];
        settings_out.language_code = {mem[`HCR_OFS_LANG_HIGH], mem[`HCR_OFS_LANG_LOW]};
        settings_out.charge_enable = mem[`HCR_OFS_CHARGE];
        settings_out.boost_up = mem[`HCR_OFS_BOOST_UP];
        settings_out.boost_down = mem[`HCR_OFS_BOOST_DOWN];
        settings_out.swap = mem[`HCR_OFS_SWAP];
        settings_out.remap = {mem[`HCR_OFS_MAP_THREE_FOUR], mem[`HCR_OFS_MAP_ONE_TWO]};
        settings_out.command = command;
    end

endmodule

// File: common/hcr_cfg.svh
// Offsets, reset values and select codes of the hub configuration register set
`ifndef HCR_CFG_SVH
`define HCR_CFG_SVH

`define HCR_ADDR_W 8
`define HCR_DATA_W 8
`define HCR_OFS_VENDOR_LOW 8'h00
`define HCR_OFS_VENDOR_HIGH 8'h01
`define HCR_OFS_PRODUCT_LOW 8'h02
`define HCR_OFS_PRODUCT_HIGH 8'h03
`define HCR_OFS_RELEASE_LOW 8'h04
`define HCR_OFS_RELEASE_HIGH 8'h05
`define HCR_OFS_CFG_ONE 8'h06
`define HCR_OFS_CFG_TWO 8'h07
`define HCR_OFS_CFG_THREE 8'h08
`define HCR_OFS_FIXED_PORTS 8'h09
`define HCR_OFS_OFF_SELF 8'h0a
`define HCR_OFS_OFF_BUS 8'h0b
`define HCR_OFS_BUDGET_SELF 8'h0c
`define HCR_OFS_BUDGET_BUS 8'h0d
`define HCR_OFS_CURR_SELF 8'h0e
`define HCR_OFS_CURR_BUS 8'h0f
`define HCR_OFS_POWER_DELAY 8'h10
`define HCR_OFS_LANG_HIGH 8'h11
`define HCR_OFS_LANG_LOW 8'h12
`define HCR_OFS_MAKER_LEN 8'h13
`define HCR_OFS_PRODUCT_LEN 8'h14
`define HCR_OFS_SERIAL_LEN 8'h15
`define HCR_OFS_MAKER_TEXT 8'h16
`define HCR_OFS_PRODUCT_TEXT 8'h54
`define HCR_OFS_SERIAL_TEXT 8'h92
`define HCR_OFS_SERIAL_END 8'hcf
`define HCR_OFS_CHARGE 8'hd0
`define HCR_OFS_RSVD_E0 8'he0
`define HCR_OFS_RSVD_F5 8'hf5
`define HCR_OFS_BOOST_UP 8'hf6
`define HCR_OFS_RSVD_F7 8'hf7
`define HCR_OFS_BOOST_DOWN 8'hf8
`define HCR_OFS_RSVD_F9 8'hf9
`define HCR_OFS_SWAP 8'hfa
`define HCR_OFS_MAP_ONE_TWO 8'hfb
`define HCR_OFS_MAP_THREE_FOUR 8'hfc
`define HCR_OFS_RSVD_FD 8'hfd
`define HCR_OFS_RSVD_FE 8'hfe
`define HCR_OFS_COMMAND 8'hff

`define HCR_RST_ZERO 8'h00
`define HCR_RST_CFG_ONE 8'h9b
`define HCR_RST_CFG_TWO 8'h20
`define HCR_RST_CFG_THREE 8'h02
`define HCR_RST_BUDGET_SELF 8'h01
`define HCR_RST_BUDGET_BUS 8'h32
`define HCR_RST_CURR_SELF 8'h01
`define HCR_RST_CURR_BUS 8'h32
`define HCR_RST_POWER_DELAY 8'h32

`define HCR_SEL_DEFAULT 2'h0
`define HCR_SEL_SMBUS 2'h1
`define HCR_SEL_DEFAULT_BUS 2'h2
`define HCR_SEL_EEPROM 2'h3

`define HCR_SPACE 256

`endif

// File: common/hcr_pkg.sv
// Types of the hub configuration register set
package hcr_pkg;

    typedef enum logic [1:0] {
        HCR_SRC_DEFAULT,
        HCR_SRC_SMBUS,
        HCR_SRC_DEFAULT_BUS,
        HCR_SRC_EEPROM
    } hcr_source_t;

    typedef enum logic [1:0] {
        HCR_ST_WAIT_STRAP,
        HCR_ST_LOAD,
        HCR_ST_READY
    } hcr_state_t;

    // One byte access from the configuring interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hcr_access_t;

    // Identification words and power settings for the hub core
    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [15:0] release_number;
        logic [7:0] config_one;
        logic [7:0] config_two;
        logic [7:0] config_three;
        logic [7:0] fixed_ports;
        logic [7:0] off_self;
        logic [7:0] off_bus;
        logic [7:0] budget_self;
        logic [7:0] budget_bus;
        logic [7:0] current_self;
        logic [7:0] current_bus;
        logic [7:0] power_delay;
        logic [15:0] language_code;
        logic [7:0] charge_enable;
        logic [7:0] boost_up;
        logic [7:0] boost_down;
        logic [7:0] swap;
        logic [15:0] remap;
        logic [7:0] command;
    } hcr_settings_t;

endpackage

// File: dv/hcr_register_set_chk.sv
// Port-level assertions for the hub configuration register set
`timescale 1ns/100ps

module hcr_register_set_chk (
    // Clock, reset and enable
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Access side
    input wire logic [1:0] cfg_select_in,
    input wire hcr_pkg::hcr_access_t access_in,
    input wire logic load_done_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    // Status and contents
    input wire hcr_pkg::hcr_source_t source_out,
    input wire logic smbus_mode_out,
    input wire logic eeprom_mode_out,
    input wire logic config_ready_out,
    input wire hcr_pkg::hcr_settings_t settings_out
);
    logic ew;
    logic ext;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Write taken from an external source
    assign ext = smbus_mode_out || eeprom_mode_out;
    assign ew = access_in.wr && clk_en_in && ext;
    ////////////////////////////////////////////////////////////////
    a_rvalid_after_rd: assert property (access_in.rd && clk_en_in |=> rvalid_out)
        else $error("no read answer");
    a_vendor_low: assert property (ew && access_in.addr == 8'h00 |=>
        settings_out.vendor_id[7:0] == $past(access_in.wdata)) else $error("vendor low");
    a_vendor_high: assert property (ew && access_in.addr == 8'h01 |=>
        settings_out.vendor_id[15:8] == $past(access_in.wdata)) else $error("vendor high");
    a_product_low: assert property (ew && access_in.addr == 8'h02 |=>
        settings_out.product_id[7:0] == $past(access_in.wdata)) else $error("product low");
    a_product_high: assert property (ew && access_in.addr == 8'h03 |=>
        settings_out.product_id[15:8] == $past(access_in.wdata)) else $error("product high");
    a_cmd_smbus_only: assert property (!smbus_mode_out |-> settings_out.command == 8'h00)
        else $error("command set outside smbus");
    a_cmd_read_zero: assert property (access_in.rd && access_in.addr == 8'hff &&
        !smbus_mode_out |=> rdata_out == 8'h00) else $error("command read");
    a_default_image: assert property ($rose(config_ready_out) && !ext |->
        {settings_out.config_one, settings_out.config_two, settings_out.config_three,
        settings_out.current_self, settings_out.current_bus, settings_out.fixed_ports,
        settings_out.charge_enable} == 56'h9b2002_0132_0000) else $error("default image");
    a_eeprom_blank: assert property ($rose(eeprom_mode_out) |-> settings_out == '0)
        else $error("eeprom image not blank");
endmodule

// File: dv/hcr_host_mdl.sv
// Configuring party model: select pins, byte accesses, end of load
`timescale 1ns/100ps

module hcr_host_mdl (
    // Clock
    input wire logic core_clk_in,
    // Configuring side
    output hcr_pkg::hcr_access_t access_out,
    output logic [1:0] cfg_select_out,
    output logic load_done_out,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in
);
    initial begin
        access_out = '0;
        cfg_select_out = 2'h0;
        load_done_out = 1'b0;
    end
    // Select pins held across reset release
    task automatic strap(input logic [1:0] s);
        cfg_select_out = s;
    endtask
    // One write; idle lines then flip away from the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        access_out = '{1'b1, 1'b0, a, d};
        @(negedge core_clk_in);
        access_out = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // One read; answer taken at the next falling edge, one cycle after the request
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge core_clk_in);
        access_out = '{1'b0, 1'b1, a, 8'h5a};
        @(negedge core_clk_in);
        access_out = '{1'b0, 1'b0, ~a, 8'ha5};
        ok = rvalid_in;
        d = rdata_in;
    endtask
    // End of the external load phase
    task automatic done();
        @(negedge core_clk_in);
        load_done_out = 1'b1;
        @(negedge core_clk_in);
        load_done_out = 1'b0;
    endtask
endmodule

// File: dv/hcr_register_set_tb.sv
// Directed testbench of the hub configuration register set
`timescale 1ns/100ps

module hcr_register_set_tb;
    logic core_clk_in;
    logic reset_n_in;
    logic [1:0] sel;
    logic load_done;
    logic [7:0] rdata;
    logic rvalid;
    logic smbus_mode;
    logic eeprom_mode;
    logic ready;
    logic [7:0] d;
    logic ok;
    hcr_pkg::hcr_access_t access;
    hcr_pkg::hcr_source_t source;
    hcr_pkg::hcr_settings_t st;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] da [12] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
        8'hd0, 8'h13, 8'h16};
    logic [7:0] dv [12] = '{8'h9b, 8'h20, 8'h02, 8'h00, 8'h01, 8'h32, 8'h01, 8'h32, 8'h32,
        8'h00, 8'h00, 8'h00};
    logic [7:0] xa [8] = '{8'h53, 8'h54, 8'h91, 8'h92, 8'hcf, 8'hd0, 8'hff, 8'he0};
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
    ////////////////////////////////////////////////////////////////
    hcr_register_set dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .clk_en_in(1'b1), .cfg_select_in(sel), .access_in(access), .load_done_in(load_done),
        .rdata_out(rdata), .rvalid_out(rvalid), .source_out(source),
        .smbus_mode_out(smbus_mode), .eeprom_mode_out(eeprom_mode),
        .config_ready_out(ready), .settings_out(st));
    hcr_host_mdl host_u (.core_clk_in(core_clk_in), .access_out(access),
        .cfg_select_out(sel), .load_done_out(load_done), .rdata_in(rdata), .rvalid_in(rvalid));
    // Clock and hang guard
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Reset for 4 cycles, then wait until accesses are allowed
    task automatic start(input logic [1:0] s);
        reset_n_in = 1'b0;
        host_u.strap(s);
        repeat (4) @(negedge core_clk_in);
        reset_n_in = 1'b1;
        repeat (4) @(posedge core_clk_in);
        // Look once the source and ready flops have settled
        @(negedge core_clk_in);
        `CHK("source", s, source)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d, ok);
        `CHK("rvalid", 1'b1, ok)
        `CHK("rdata", e, d)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        reset_n_in = 1'b0;
        // Internal default modes 00 and 10, writes refused
        for (int m = 0; m < 4; m += 2) begin
            start(m[1:0]);
            `CHK("ready", 1'b1, ready)
            host_u.wr(8'h06, 8'h55);
            for (int i = 0; i < 12; i++) rdchk(da[i], dv[i]);
            rdchk(8'hff, 8'h00);
        end
        // EEPROM source: blank image, no command register
        start(2'h3);
        for (int i = 0; i < 12; i++) rdchk(da[i], 8'h00);
        host_u.wr(8'hff, 8'h77);
        rdchk(8'hff, 8'h00);
        host_u.wr(8'h0e, 8'h44);
        host_u.done();
        `CHK("ready", 1'b1, ready)
        rdchk(8'h0e, 8'h44);
        // SMBus source: identifiers, string bounds, reserved and command bytes
        start(2'h1);
        host_u.wr(8'h00, 8'h34);
        host_u.wr(8'h01, 8'h12);
        host_u.wr(8'h02, 8'h78);
        host_u.wr(8'h03, 8'h56);
        `CHK("vendor", 16'h1234, st.vendor_id)
        `CHK("product", 16'h5678, st.product_id)
        rdchk(8'h01, 8'h12);
        rdchk(8'h02, 8'h78);
        for (int i = 0; i < 7; i++) host_u.wr(xa[i], xa[i] ^ 8'h3c);
        host_u.wr(8'he0, 8'h00);
        for (int i = 0; i < 8; i++) rdchk(xa[i], (i == 7) ? 8'h00 : xa[i] ^ 8'h3c);
        `CHK("command", 8'hc3, st.command)
        host_u.rd(8'hd5, d, ok);
        close_out();
    end
endmodule

bind hcr_register_set hcr_register_set_chk chk_u (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .cfg_select_in(cfg_select_in),
    .access_in(access_in), .load_done_in(load_done_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .source_out(source_out), .smbus_mode_out(smbus_mode_out),
    .eeprom_mode_out(eeprom_mode_out), .config_ready_out(config_ready_out),
    .settings_out(settings_out));
